// ===== hdl/mci_params.svh
// Constants for the modem core interrupt unit.
// Operation
// - Reset vectors to 0x0000 first, then 0x0004, 0x0008, 0x000C, 0x0010, 0x0014, power-down to 0x002C and the last source to 0x0028.
// - A reset leaves interrupt servicing disabled, except for power-down, until software enables it.
// - The edge-only request pin latches a request on a transition, not on a held level.
// - Software picks level or edge sensing for the highest external request pin.
// - Shared request pins keep interrupt and flag functions at the same time.
// - An enabled shared-pin interrupt fires whether the pin is driven from outside or by the flag output.
// - Each serial transmit and receive section requests once per finished word.
// - In automatic buffering a serial section requests only when the whole buffer is done.
// - All sources are prioritised and maskable except power-down and reset.
// - The two low-level request pins are level-sensitive and request while held.
// - Each processor answers eleven sources plus reset.
`ifndef MCI_PARAMS_SVH
`define MCI_PARAMS_SVH

// ***************************************************************
// Source indices, lowest index has highest priority.
// ***************************************************************
`define MCI_NUM_SRC 11
`define MCI_SRC_PWRDN 4'h0
`define MCI_SRC_EXT_REQ_EDGE_OR_LEVEL 4'h1
`define MCI_SRC_LVL_HI 4'h2
`define MCI_SRC_LVL_LO 4'h3
`define MCI_SRC_SP0_TX 4'h4
`define MCI_SRC_SP0_RX 4'h5
`define MCI_SRC_EDGE 4'h6
`define MCI_SRC_BYTE 4'h7
`define MCI_SRC_SP1_TX 4'h8
`define MCI_SRC_SP1_RX 4'h9
`define MCI_SRC_TIMER 4'ha
`define MCI_IDX_RESET 4'hf

// ***************************************************************
// Vector addresses.
// ***************************************************************
`define MCI_VEC_RESET 16'h0000
`define MCI_VEC_EXT_REQ_EDGE_OR_LEVEL 16'h0004
`define MCI_VEC_LVL_HI 16'h0008
`define MCI_VEC_LVL_LO 16'h000c
`define MCI_VEC_SP0_TX 16'h0010
`define MCI_VEC_SP0_RX 16'h0014
`define MCI_VEC_EDGE 16'h0018
`define MCI_VEC_BYTE 16'h001c
`define MCI_VEC_SP1_TX 16'h0020
`define MCI_VEC_SP1_RX 16'h0024
`define MCI_VEC_TIMER 16'h0028
`define MCI_VEC_PWRDN 16'h002c

// ***************************************************************
// Reset values.
// ***************************************************************
`define MCI_PEND_RST 11'h000
`define MCI_PIN_IDLE 1'h1

`endif

// ===== hdl/mci_pkg.sv
// Types shared by the modem core interrupt unit.
package mci_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_WAIT} mci_state_e;
    typedef logic [10:0] mci_src_t;
    typedef logic [15:0] mci_vec_t;
endpackage

// ===== hdl/mci_req_detect.sv
// Synchroniser and level/edge detector for one active-low request pin.
`timescale 1ns/1ps
`include "mci_params.svh"
module mci_req_detect
    import mci_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pin_n,
    output logic req_level,
    output logic req_fall
);
    logic sync1_reg, sync2_reg, last_reg;
    logic sync1_next, sync2_next, last_next;

    // Two flip-flops bring the pin into the clock domain, a third
    // remembers the previous settled level for the edge detector.
    always_comb begin
        sync1_next = pin_n;
        sync2_next = sync1_reg;
        last_next = sync2_reg;
    end

    // Registers with the pin idle (high) after reset.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync1_reg <= `MCI_PIN_IDLE;
            sync2_reg <= `MCI_PIN_IDLE;
            last_reg <= `MCI_PIN_IDLE;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg <= last_next;
        end
    end

    // Asserted level and one-cycle falling-edge pulse.
    assign req_level = ~sync2_reg;
    assign req_fall = last_reg & ~sync2_reg;
endmodule

// ===== hdl/mci_top.sv
// Interrupt unit of one modem processor: pending, masking, vectoring.
`timescale 1ns/1ps
`include "mci_params.svh"
module mci_top
    import mci_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ext_req_edge_or_level_n,
    input wire logic ext_req_level_high_n,
    input wire logic ext_req_level_low_n,
    input wire logic ext_req_edge_only_n,
    input wire logic ext_req_one_n,
    input wire logic ext_req_zero_n,
    input wire logic [3:0] flag_dout,
    input wire logic [3:0] flag_dir,
    input wire logic [2:0] edge_sel,
    input wire logic sp1_pin_irq,
    input wire logic [3:0] sp_word_done,
    input wire logic [3:0] sp_buf_done,
    input wire logic [3:0] sp_autobuf,
    input wire logic byte_done,
    input wire logic timer_done,
    input wire logic pwrdn_req,
    input wire logic [10:1] interrupt_enable_mask,
    input wire logic int_enable_set,
    input wire logic int_enable_clr,
    input wire mci_src_t sw_set,
    input wire mci_src_t sw_clr,
    input wire logic core_ack,
    output logic flag_io_bit7_out,
    output logic flag_io_bit7_oe,
    output logic flag_io_bit6_out,
    output logic flag_io_bit6_oe,
    output logic flag_io_bit5_out,
    output logic flag_io_bit5_oe,
    output logic flag_io_bit4_out,
    output logic flag_io_bit4_oe,
    output logic vec_req,
    output mci_vec_t vec_addr,
    output mci_src_t pending,
    output logic int_enabled
);
    // ***********************************************************
    // Pin detectors
    // ***********************************************************
    logic [5:0] pins_n, lvl, fall;
    assign pins_n = {ext_req_zero_n, ext_req_one_n, ext_req_edge_only_n,
                     ext_req_level_low_n, ext_req_level_high_n,
                     ext_req_edge_or_level_n};

    // One synchroniser per request pin; the pin is read as a plain
    // input while the flag driver may be driving it too.
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_pin
            mci_req_detect u_det (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .pin_n(pins_n[gi]),
                .req_level(lvl[gi]),
                .req_fall(fall[gi])
            );
        end
    endgenerate

    // Maps a source index to its vector address.
    function automatic mci_vec_t vec_of(input logic [3:0] idx);
        unique case (idx)
            `MCI_SRC_PWRDN: vec_of = `MCI_VEC_PWRDN;
            `MCI_SRC_EXT_REQ_EDGE_OR_LEVEL: vec_of = `MCI_VEC_EXT_REQ_EDGE_OR_LEVEL;
            `MCI_SRC_LVL_HI: vec_of = `MCI_VEC_LVL_HI;
            `MCI_SRC_LVL_LO: vec_of = `MCI_VEC_LVL_LO;
            `MCI_SRC_SP0_TX: vec_of = `MCI_VEC_SP0_TX;
            `MCI_SRC_SP0_RX: vec_of = `MCI_VEC_SP0_RX;
            `MCI_SRC_EDGE: vec_of = `MCI_VEC_EDGE;
            `MCI_SRC_BYTE: vec_of = `MCI_VEC_BYTE;
            `MCI_SRC_SP1_TX: vec_of = `MCI_VEC_SP1_TX;
            `MCI_SRC_SP1_RX: vec_of = `MCI_VEC_SP1_RX;
            `MCI_SRC_TIMER: vec_of = `MCI_VEC_TIMER;
            default: vec_of = `MCI_VEC_RESET;
        endcase
    endfunction

    // ***********************************************************
    // Pending logic
    // ***********************************************************
    mci_src_t pend_reg, pend_next, hw_set, lvl_type, lvl_now, ack_clr;
    mci_src_t active;
    logic [3:0] sp_evt;
    logic en_reg, en_next;

    // Serial sections request per word, or per buffer in autobuffer.
    assign sp_evt = (sp_autobuf & sp_buf_done) |
                    (~sp_autobuf & sp_word_done);

    // Source events and the sources that simply follow a pin level.
    always_comb begin
        hw_set = {timer_done,
                  sp1_pin_irq ? fall[5] : sp_evt[3],
                  sp1_pin_irq ? fall[4] : sp_evt[2],
                  byte_done, fall[3], sp_evt[1], sp_evt[0],
                  1'b0, 1'b0, fall[0], pwrdn_req};
        lvl_type = {1'b0, sp1_pin_irq & ~edge_sel[0],
                    sp1_pin_irq & ~edge_sel[1], 4'h0,
                    1'b1, 1'b1, ~edge_sel[2], 1'b0};
        lvl_now = {1'b0, lvl[5], lvl[4], 4'h0,
                   lvl[2], lvl[1], lvl[0], 1'b0};
    end

    // Latched bits hold until cleared, a new set beats a clear;
    // level bits track their pin.
    always_comb begin
        pend_next = (lvl_type & lvl_now) |
                    (~lvl_type & ((pend_reg & ~(sw_clr | ack_clr)) |
                                  hw_set | sw_set));
        if (int_enable_set) begin
            en_next = 1'b1;
        end else if (int_enable_clr) begin
            en_next = 1'b0;
        end else begin
            en_next = en_reg;
        end
        active = pend_reg & {interrupt_enable_mask, 1'b1} &
                 {{10{en_reg}}, 1'b1};
    end

    // Servicing of all sources but power-down is off after reset.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pend_reg <= `MCI_PEND_RST;
            en_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            en_reg <= en_next;
        end
    end

    // ***********************************************************
    // Vectoring state machine
    // ***********************************************************
    mci_state_e st_reg, st_next;
    logic req_reg, req_next, any_act;
    mci_vec_t addr_reg, addr_next;
    logic [3:0] idx_reg, idx_next, sel;

    // Fixed priority: the lowest active index wins.
    always_comb begin
        sel = 4'h0;
        any_act = 1'b0;
        for (int i = `MCI_NUM_SRC - 1; i >= 0; i--) begin
            if (active[i]) begin
                sel = i[3:0];
                any_act = 1'b1;
            end
        end
    end

    // Issues one vector and waits for the core to take it.
    always_comb begin
        st_next = st_reg;
        req_next = req_reg;
        addr_next = addr_reg;
        idx_next = idx_reg;
        ack_clr = '0;
        unique case (st_reg)
            ST_IDLE: begin
                if (any_act) begin
                    req_next = 1'b1;
                    addr_next = vec_of(sel);
                    idx_next = sel;
                    st_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (core_ack) begin
                    req_next = 1'b0;
                    if (idx_reg != `MCI_IDX_RESET) begin
                        ack_clr[idx_reg] = 1'b1;
                    end
                    st_next = ST_IDLE;
                end
            end
        endcase
    end

    // Reset presents the reset vector until the core takes it.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg <= ST_WAIT;
            req_reg <= 1'b1;
            addr_reg <= `MCI_VEC_RESET;
            idx_reg <= `MCI_IDX_RESET;
        end else begin
            st_reg <= st_next;
            req_reg <= req_next;
            addr_reg <= addr_next;
            idx_reg <= idx_next;
        end
    end

    // ***********************************************************
    // Flag outputs
    // ***********************************************************
    logic [3:0] fout_reg, foe_reg;

    // Flag drivers run independently of the interrupt path.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fout_reg <= 4'h0;
            foe_reg <= 4'h0;
        end else begin
            fout_reg <= flag_dout;
            foe_reg <= flag_dir;
        end
    end

    assign {flag_io_bit7_out, flag_io_bit6_out, flag_io_bit5_out,
            flag_io_bit4_out} = fout_reg;
    assign {flag_io_bit7_oe, flag_io_bit6_oe, flag_io_bit5_oe,
            flag_io_bit4_oe} = foe_reg;
    assign vec_req = req_reg;
    assign vec_addr = addr_reg;
    assign pending = pend_reg;
    assign int_enabled = en_reg;

    // ***********************************************************
    // Assertions
    // ***********************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_reset_vector_out: assert property (
        $past(sys_rst) |-> vec_req && vec_addr == 16'h0000)
        else $error("reset vector not presented");
    a_reset_disables_en: assert property (
        $past(sys_rst) && !int_enable_set |-> !int_enabled)
        else $error("servicing enabled out of reset");
    a_edge_only_latch: assert property (
        fall[3] |=> pending[`MCI_SRC_EDGE])
        else $error("edge request not latched");
    a_sense_level_mode: assert property (
        !edge_sel[2] && !$past(sys_rst) |=> pending[1] == $past(lvl[0]))
        else $error("level mode not following pin");
    a_level_pin_track: assert property (
        !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |->
        pending[2] == !$past(ext_req_level_high_n, 3))
        else $error("level request not tracking pin");
    a_flag_oe_kept: assert property (
        !$past(sys_rst) |-> {flag_io_bit7_oe, flag_io_bit4_oe} ==
        {$past(flag_dir[3]), $past(flag_dir[0])})
        else $error("flag drive lost");
    a_word_irq_set: assert property (
        sp_word_done[0] && !sp_autobuf[0] |=> pending[`MCI_SRC_SP0_TX])
        else $error("word request missing");
    a_autobuf_hold: assert property (
        sp_autobuf[0] && !sp_buf_done[0] && !sw_set[4] && !pending[4]
        |=> !pending[4])
        else $error("autobuffer request too early");
    a_mask_gates: assert property (
        $rose(vec_req) && idx_reg != 4'h0 && idx_reg != 4'hf |->
        ((({$past(interrupt_enable_mask), 1'b0} & (11'h001 << idx_reg)) !=
        11'h000) && $past(int_enabled)))
        else $error("masked source vectored");
    a_pwrdn_unmasked: assert property (
        st_reg == ST_IDLE && pending[0] |=> vec_req && vec_addr == 16'h002c)
        else $error("power-down not vectored");
    a_priority_pick: assert property (
        $rose(vec_req) && idx_reg != 4'hf |->
        ($past(active) & ((11'h001 << idx_reg) - 11'h001)) == 11'h000)
        else $error("lower priority won");
    a_vector_legal: assert property (
        vec_req |-> vec_addr[1:0] == 2'h0 && vec_addr <= 16'h002c)
        else $error("illegal vector");
    a_edge_pending_hold: assert property (
        pending[6] && !sw_clr[6] &&
        !(core_ack && idx_reg == 4'h6 && st_reg == ST_WAIT) |=> pending[6])
        else $error("edge request dropped");

    c_reset_taken: cover property ($past(sys_rst) ##[1:20] core_ack);
    c_pwrdn_served: cover property (vec_req && vec_addr == 16'h002c);
    c_edge_served: cover property (vec_req && vec_addr == 16'h0018);
    c_level_served: cover property (vec_req && vec_addr == 16'h0008);
endmodule

// ===== sim/mci_pin_driver.sv
// Model of the outside devices that pull the six request pins low.
`timescale 1ns/1ps
module mci_pin_driver (
    input wire logic [5:0] assert_req,
    output logic [5:0] pin_n
);
    // Open-drain drivers on pulled-up pins, so a released pin reads high.
    assign pin_n = ~assert_req;
endmodule

// ===== sim/modem_core_interrupt_unit_bench.sv
// Self-checking testbench for the modem core interrupt unit.
`timescale 1ns/1ps
module modem_core_interrupt_unit_bench
    import mci_pkg::*;
;
    // ****************************************************************
    // Stimulus, pins and design.
    // ****************************************************************
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] ext_on = '0;
    logic [5:0] pin_n;
    logic [5:0] pin_w;
    logic [3:0] fdout = '0;
    logic [3:0] fdir = '0;
    logic [3:0] wd = '0;
    logic [3:0] bd = '0;
    logic [3:0] ab = '0;
    logic [2:0] esel = '0;
    logic sp1pin = 1'b0;
    logic byte_d = 1'b0;
    logic timer_d = 1'b0;
    logic pwrdn = 1'b0;
    logic ieset = 1'b0;
    logic ieclr = 1'b0;
    logic ack = 1'b0;
    logic [10:1] mask = '1;
    mci_src_t swset = '0;
    mci_src_t swclr = '0;
    logic [3:0] fout;
    logic [3:0] foe;
    logic vec_req;
    mci_vec_t vec_addr;
    mci_src_t pending;
    logic int_enabled;
    int n_fail = 0;
    int n_checks = 0;

    // The clock toggles every 20 ns, giving a period of 40 ns.
    always #20 mclk = ~mclk;

    // A driven-low flag output pulls its shared pin low as well.
    assign pin_w[5:2] = pin_n[5:2] & ~(foe & ~fout);
    assign pin_w[1:0] = pin_n[1:0];

    mci_pin_driver far_u (.assert_req(ext_on), .pin_n(pin_n));

    mci_top dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .ext_req_edge_or_level_n(pin_w[5]), .ext_req_level_high_n(pin_w[4]),
        .ext_req_level_low_n(pin_w[3]), .ext_req_edge_only_n(pin_w[2]),
        .ext_req_one_n(pin_w[1]), .ext_req_zero_n(pin_w[0]),
        .flag_dout(fdout), .flag_dir(fdir), .edge_sel(esel),
        .sp1_pin_irq(sp1pin), .sp_word_done(wd), .sp_buf_done(bd),
        .sp_autobuf(ab), .byte_done(byte_d), .timer_done(timer_d),
        .pwrdn_req(pwrdn), .interrupt_enable_mask(mask),
        .int_enable_set(ieset), .int_enable_clr(ieclr), .sw_set(swset),
        .sw_clr(swclr), .core_ack(ack),
        .flag_io_bit7_out(fout[3]), .flag_io_bit7_oe(foe[3]),
        .flag_io_bit6_out(fout[2]), .flag_io_bit6_oe(foe[2]),
        .flag_io_bit5_out(fout[1]), .flag_io_bit5_oe(foe[1]),
        .flag_io_bit4_out(fout[0]), .flag_io_bit4_oe(foe[0]),
        .vec_req(vec_req), .vec_addr(vec_addr), .pending(pending),
        .int_enabled(int_enabled));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits a bounded time for a vector and compares its address.
    task automatic waitv(input logic [15:0] exp);
        int i;
        i = 0;
        while (vec_req !== 1'b1 && i < 20) begin
            @(negedge mclk);
            i++;
        end
        chk("vec_addr", exp, (vec_req === 1'b1) ? vec_addr : 16'hxxxx);
    endtask

    // Acknowledges the vector, then lets the idle cycle pass.
    task automatic ackv();
        ack = 1'b1;
        @(negedge mclk);
        ack = 1'b0;
        @(negedge mclk);
    endtask

    task automatic take(input logic [15:0] exp);
        waitv(exp);
        ackv();
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge mclk);
            chk("vec_req", 16'h0, {15'h0, vec_req});
        end
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset();
        chk("reset vec_req", 16'h1, {15'h0, vec_req});
        chk("int_enabled", 16'h0, {15'h0, int_enabled});
        chk("pending", 16'h0, {5'h0, pending});
        take(16'h0000);
        ext_on[4] = 1'b1;
        quiet(8);
        pwrdn = 1'b1;
        @(negedge mclk);
        pwrdn = 1'b0;
        take(16'h002c);
        ext_on[4] = 1'b0;
        repeat (5) @(negedge mclk);
        ieset = 1'b1;
        @(negedge mclk);
        ieset = 1'b0;
        quiet(3);
        chk("int_enabled", 16'h1, {15'h0, int_enabled});
        ieclr = 1'b1;
        @(negedge mclk);
        ieclr = 1'b0;
        chk("int_enabled", 16'h0, {15'h0, int_enabled});
        ieset = 1'b1;
        ieclr = 1'b1;
        @(negedge mclk);
        ieset = 1'b0;
        ieclr = 1'b0;
        chk("int_enabled", 16'h1, {15'h0, int_enabled});
        $display("test reset done");
    endtask

    task automatic t_prio();
        esel = 3'b100;
        swset = 11'h372;
        byte_d = 1'b1;
        timer_d = 1'b1;
        @(negedge mclk);
        swset = '0;
        byte_d = 1'b0;
        timer_d = 1'b0;
        for (int i = 0; i < 8; i++) begin
            take(i == 0 ? 16'h0004 : 16'h000c + 16'(4 * i));
        end
        quiet(4);
        $display("test priority done");
    endtask

    task automatic t_level(input int b, input logic [15:0] exp);
        ext_on[b] = 1'b1;
        waitv(exp);
        ackv();
        waitv(exp);
        ext_on[b] = 1'b0;
        repeat (5) @(negedge mclk);
        ackv();
        quiet(4);
    endtask

    task automatic t_edge();
        mask[6] = 1'b0;
        ext_on[2] = 1'b1;
        repeat (2) @(negedge mclk);
        ext_on[2] = 1'b0;
        quiet(6);
        chk("pending edge", 16'h1, {15'h0, pending[6]});
        mask[6] = 1'b1;
        take(16'h0018);
        chk("pending edge", 16'h0, {15'h0, pending[6]});
        ext_on[2] = 1'b1;
        take(16'h0018);
        quiet(8);
        ext_on[2] = 1'b0;
        repeat (4) @(negedge mclk);
        mask[6] = 1'b0;
        ext_on[2] = 1'b1;
        repeat (2) @(negedge mclk);
        ext_on[2] = 1'b0;
        repeat (3) @(negedge mclk);
        chk("pending edge", 16'h1, {15'h0, pending[6]});
        swclr[6] = 1'b1;
        @(negedge mclk);
        swclr[6] = 1'b0;
        chk("pending edge", 16'h0, {15'h0, pending[6]});
        mask[6] = 1'b1;
        quiet(3);
        $display("test edge done");
    endtask

    task automatic t_serial();
        for (int i = 0; i < 4; i++) begin
            wd[i] = 1'b1;
            @(negedge mclk);
            wd[i] = 1'b0;
            take(16'h0010 + 16'(i * 4) + ((i > 1) ? 16'h8 : 16'h0));
        end
        ab = 4'hf;
        wd = 4'hf;
        @(negedge mclk);
        wd = '0;
        quiet(6);
        bd = 4'hf;
        @(negedge mclk);
        bd = '0;
        for (int i = 0; i < 4; i++) begin
            take(16'h0010 + 16'(i * 4) + ((i > 1) ? 16'h8 : 16'h0));
        end
        ab = '0;
        $display("test serial done");
    endtask

    task automatic t_flag();
        esel = 3'b000;
        fdir = 4'h8;
        fdout = 4'h8;
        repeat (2) @(negedge mclk);
        chk("flag oe", 16'h8, {12'h0, foe});
        chk("flag out", 16'h8, {12'h0, fout});
        fdout = 4'h0;
        waitv(16'h0004);
        fdout = 4'h8;
        repeat (5) @(negedge mclk);
        ackv();
        quiet(4);
        fdir = 4'h0;
        $display("test flag done");
    endtask

    // Edge sensing on the serial-one request pins latches once per fall.
    task automatic t_pin_edge();
        sp1pin = 1'b1;
        esel = 3'b011;
        ext_on[1] = 1'b1;
        take(16'h0020);
        quiet(6);
        ext_on[1] = 1'b0;
        ext_on[0] = 1'b1;
        take(16'h0024);
        quiet(6);
        ext_on[0] = 1'b0;
        repeat (4) @(negedge mclk);
        sp1pin = 1'b0;
        $display("test pin edge done");
    endtask

    // A reset in mid-run brings back the reset vector and the disabled
    // state while a level request is held across it.
    task automatic t_rerst();
        ext_on[4] = 1'b1;
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        chk("int_enabled", 16'h0, {15'h0, int_enabled});
        take(16'h0000);
        quiet(6);
        chk("pending", 16'h4, {5'h0, pending});
        ext_on[4] = 1'b0;
        repeat (4) @(negedge mclk);
        $display("test second reset done");
    endtask

    // ****************************************************************
    // Main sequence, watchdog and verdict.
    // ****************************************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Runs the scenarios after four cycles of reset.
    initial begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        t_reset();
        t_prio();
        t_level(4, 16'h0008);
        t_level(3, 16'h000c);
        esel = 3'b000;
        t_level(5, 16'h0004);
        esel = 3'b100;
        ext_on[5] = 1'b1;
        take(16'h0004);
        quiet(8);
        ext_on[5] = 1'b0;
        sp1pin = 1'b1;
        t_level(1, 16'h0020);
        t_level(0, 16'h0024);
        t_pin_edge();
        sp1pin = 1'b0;
        $display("test sensing done");
        t_edge();
        t_serial();
        t_flag();
        t_rerst();
        give_verdict();
    end

    // Cuts a hang short well beyond the expected run of some 300 cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        give_verdict();
    end
endmodule
